// file: verilog/som_top.sv
// Safety output manager: pairs, warnings, alarms, auto-reset, muting, pins
//
// Notes on behaviour
// (R1) Object in active protective zone turns off every configured pair that is not muted or overridden.
// (R2) One to three pairs by configuration, capped by connector; halves together.
// (R3) Caution-zone-only detection never turns the pairs off.
// (R4) At most two caution zones, each with its own warning output.
// (R5) No warning output assigned means no caution zone detection at all.
// (R6) Warning polarity: low conducts when clear, high conducts when occupied.
// (R7) Alarm one follows the dirty-window message when enabled.
// (R8) Alarm two follows any fault that turns the pairs off.
// (R9) Auto-reset retries every ten seconds, resumes once the error clears; the code stops retrying and goes idle when it clears.
// (R10) More than five lockouts in fifteen minutes inhibit auto-reset until power-up.
// (R11) Muting, lamp, override per first and second pair; third never muted.
// (R12) Mute sensors keep muted pairs on while objects pass.
// (R13) Enabling muting lowers the maximum number of zone sets.
// (R14) Lamp output driven throughout the muted condition when enabled.
// (R15) Display shows muted state during every muting cycle.
// (R16) Override output only with muting; shows pairs manually forced on.
// (R17) First pair always on its fixed dedicated pins.
// (R18) Multipurpose pin driven as output is never sampled as input.
// (R19) Pair halves on multipurpose pins only with more than one pair.
// (R20) Only the active zone set decides pairs and warnings.
// (R21) Timers run from a millisecond tick; inhibit clears only on power-up.
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
module som_top #(
  parameter int MAX_PAIRS = 3,
  parameter int NPIN = 4,
  parameter int TICK_CYC = som_pkg::TICK_CYC,
  parameter int AR_TICKS = som_pkg::AUTORESET_MS,
  parameter int WIN_TICKS = som_pkg::LOCK_WIN_MS
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire som_pkg::som_zone_t I_ZONE,
  input wire som_pkg::som_stat_t I_STAT,
  input wire logic [1:0] I_MUTE_SENSOR,
  input wire logic I_OVERRIDE,
  input wire logic [3:0] I_MPIN_IN,
  output logic [1:0] O_PAIR1,
  output logic [3:0] O_MPIN_OUT,
  output logic [3:0] O_MPIN_OE,
  output logic [3:0] O_MPIN_SAMPLED,
  output logic O_DISPLAY_MUTED,
  output logic O_RESET_TRY,
  output logic O_AUTORESET_INHIBIT,
  output logic [6:0] O_MAX_ZONE_SETS
);

  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int AW = $clog2(AR_TICKS + 1);
  localparam int WW = $clog2(WIN_TICKS + 1);

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] clampv(input logic [1:0] v,
                                        input logic [1:0] lo,
                                        input logic [1:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] mute_s1_q, mute_s2_q;
  logic ovr_s1_q, ovr_s2_q;
  logic [3:0] mpin_s1_q, mpin_s2_q;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      mute_s1_q <= 2'h0;
      mute_s2_q <= 2'h0;
      ovr_s1_q <= 1'b0;
      ovr_s2_q <= 1'b0;
      mpin_s1_q <= 4'h0;
      mpin_s2_q <= 4'h0;
    end else begin
      mute_s1_q <= I_MUTE_SENSOR;
      mute_s2_q <= mute_s1_q;
      ovr_s1_q <= I_OVERRIDE;
      ovr_s2_q <= ovr_s1_q;
      mpin_s1_q <= I_MPIN_IN;
      mpin_s2_q <= mpin_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state
  som_pkg::som_ctrl_t ctrl_q;
  logic [15:0] mpin_cfg_q;
  logic [31:0] rdat;
  logic [31:0] stat_w;
  logic [31:0] lock_w;
  logic wb_req;

  assign wb_req = I_WB_CYC & I_WB_STB;

  always_comb begin
    case (I_WB_ADR)
      som_pkg::CTRL_OFS: rdat = {17'h0, ctrl_q};
      som_pkg::MPIN_OFS: rdat = {16'h0, mpin_cfg_q};
      som_pkg::STAT_OFS: rdat = stat_w;
      som_pkg::LOCK_OFS: rdat = lock_w;
      default: rdat = 32'h0;
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0;
    end else begin
      O_WB_ACK <= wb_req & ~O_WB_ACK;
      O_WB_DAT <= (wb_req & ~O_WB_ACK) ? rdat : 32'h0;
    end
  end

  // Merged words kept apart: a function result cannot be part-selected
  logic [31:0] ctrl_m;
  logic [31:0] mpin_m;

  assign ctrl_m = wmerge({17'h0, ctrl_q}, I_WB_DAT, I_WB_SEL);
  assign mpin_m = wmerge({16'h0, mpin_cfg_q}, I_WB_DAT, I_WB_SEL);

  // Write lands on the edge that the master sees ack
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      ctrl_q <= som_pkg::CTRL_RST;
      mpin_cfg_q <= som_pkg::MPIN_RST;
    end else if (wb_req & O_WB_ACK & I_WB_WE) begin
      if (I_WB_ADR == som_pkg::CTRL_OFS) begin
        ctrl_q <= som_pkg::som_ctrl_t'(ctrl_m[som_pkg::CTRL_W-1:0]);
      end
      if (I_WB_ADR == som_pkg::MPIN_OFS) begin
        mpin_cfg_q <= mpin_m[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output functions
  logic [1:0] npair, nwarn;
  logic [1:0] muted, ovr_act, keep;
  logic [2:0] keep3;
  logic active_viol;
  logic [2:0] pair_d;
  logic [1:0] warn_d, occ;
  logic [2:0] pair_q;
  logic [1:0] warn_q, muted_q, ovr_q;
  logic alarm1_q, alarm2_q;

  assign npair = clampv(ctrl_q.pair_cnt, 2'd1, 2'(MAX_PAIRS)); // R2
  assign nwarn = clampv(ctrl_q.warn_cnt, 2'd0, 2'd2); // R4
  assign active_viol = I_ZONE.zone_active & I_ZONE.protective_viol; // R20
  assign keep3 = {1'b0, keep}; // R11

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      muted[k] = ctrl_q.mute_en[k] & (&mute_s2_q); // R11 R12
      ovr_act[k] = ctrl_q.mute_en[k] & ctrl_q.ovr_en[k] & ovr_s2_q; // R16
      keep[k] = muted[k] | ovr_act[k];
    end
    for (int k = 0; k < 3; k++) begin
      // Third pair has no keep term: it can never be muted
      pair_d[k] = (2'(k) < npair) & ~I_STAT.fault & I_ZONE.zone_active
                  & (~I_ZONE.protective_viol | keep3[k]); // R1 R3
    end
    for (int w = 0; w < 2; w++) begin
      // Without an assigned output no caution zone exists at all
      occ[w] = (2'(w) < nwarn) & I_ZONE.zone_active
               & I_ZONE.caution_viol[w]; // R5 R20
      warn_d[w] = (2'(w) < nwarn) & (ctrl_q.warn_pol[w] ? occ[w]
                                                       : ~occ[w]); // R6
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      pair_q <= 3'h0;
      O_PAIR1 <= 2'h0;
      warn_q <= 2'h0;
      muted_q <= 2'h0;
      ovr_q <= 2'h0;
      O_DISPLAY_MUTED <= 1'b0;
    end else begin
      pair_q <= pair_d;
      O_PAIR1 <= {2{pair_d[0]}}; // R17
      warn_q <= warn_d;
      muted_q <= muted;
      ovr_q <= ovr_act;
      O_DISPLAY_MUTED <= |muted; // R15
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      alarm1_q <= 1'b0;
      alarm2_q <= 1'b0;
    end else begin
      alarm1_q <= ctrl_q.alarm1_en & I_STAT.dirty_window; // R7
      alarm2_q <= ctrl_q.alarm2_en & I_STAT.fault; // R8
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      O_MAX_ZONE_SETS <= 7'(som_pkg::ZS_MAX);
    end else begin
      O_MAX_ZONE_SETS <= (|ctrl_q.mute_en) ? 7'(som_pkg::ZS_MAX_MUTED)
                                            : 7'(som_pkg::ZS_MAX); // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Multipurpose pins
  logic [3:0] mp_val, mp_oe;

  always_comb begin
    mp_val = 4'h0;
    mp_oe = 4'h0;
    for (int i = 0; i < NPIN; i++) begin
      mp_oe[i] = 1'b1;
      case (som_pkg::som_mfunc_t'(mpin_cfg_q[i*4 +: 4]))
        som_pkg::MF_WARN1: begin
          mp_oe[i] = nwarn >= 2'd1; // R5
          mp_val[i] = warn_q[0];
        end
        som_pkg::MF_WARN2: begin
          mp_oe[i] = nwarn >= 2'd2; // R5
          mp_val[i] = warn_q[1];
        end
        som_pkg::MF_LAMP1: begin
          mp_oe[i] = ctrl_q.mute_en[0] & ctrl_q.lamp_en[0];
          mp_val[i] = muted_q[0]; // R14
        end
        som_pkg::MF_LAMP2: begin
          mp_oe[i] = ctrl_q.mute_en[1] & ctrl_q.lamp_en[1];
          mp_val[i] = muted_q[1]; // R14
        end
        som_pkg::MF_ALARM1: mp_val[i] = alarm1_q;
        som_pkg::MF_ALARM2: mp_val[i] = alarm2_q;
        som_pkg::MF_OVR1: begin
          mp_oe[i] = ctrl_q.mute_en[0] & ctrl_q.ovr_en[0]; // R16
          mp_val[i] = ovr_q[0];
        end
        som_pkg::MF_OVR2: begin
          mp_oe[i] = ctrl_q.mute_en[1] & ctrl_q.ovr_en[1]; // R16
          mp_val[i] = ovr_q[1];
        end
        som_pkg::MF_P2A, som_pkg::MF_P2B: begin
          mp_oe[i] = npair >= 2'd2; // R19
          mp_val[i] = pair_q[1];
        end
        som_pkg::MF_P3A, som_pkg::MF_P3B: begin
          mp_oe[i] = npair >= 2'd3; // R19
          mp_val[i] = pair_q[2];
        end
        default: begin
          mp_oe[i] = 1'b0;
          mp_val[i] = 1'b0;
        end
      endcase
      if (!mp_oe[i]) begin
        mp_val[i] = 1'b0;
      end
    end
  end

  // A pin set as output is masked from sampling in the same cycle
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      O_MPIN_OUT <= 4'h0;
      O_MPIN_OE <= 4'h0;
      O_MPIN_SAMPLED <= 4'h0;
    end else begin
      O_MPIN_OUT <= mp_val;
      O_MPIN_OE <= mp_oe;
      O_MPIN_SAMPLED <= mpin_s2_q & ~mp_oe; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick and auto-reset
  logic [TW-1:0] tick_cnt_q;
  logic tick_q;
  logic [AW-1:0] ar_cnt_q;
  logic [WW-1:0] win_cnt_q;
  logic [2:0] lock_cnt_q;
  som_pkg::som_ar_t ar_q;
  logic inhibit_q;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_cnt_q == TW'(TICK_CYC - 1); // R21
      tick_cnt_q <= (tick_cnt_q == TW'(TICK_CYC - 1)) ? '0
                                                      : tick_cnt_q + 1'b1;
    end
  end

  // Lockout window opens at first lockout; event in expiry cycle counts
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      lock_cnt_q <= 3'h0;
      win_cnt_q <= '0;
      inhibit_q <= 1'b0;
    end else begin
      if (lock_cnt_q != 3'h0 && tick_q) begin
        win_cnt_q <= win_cnt_q + 1'b1;
      end
      if (lock_cnt_q != 3'h0 && tick_q
          && win_cnt_q == WW'(WIN_TICKS - 1)) begin
        lock_cnt_q <= {2'h0, I_STAT.lockout_evt};
        win_cnt_q <= '0;
      end else if (I_STAT.lockout_evt && lock_cnt_q != 3'h7) begin
        lock_cnt_q <= lock_cnt_q + 3'h1;
      end
      if (lock_cnt_q > 3'(som_pkg::LOCK_MAX)) begin
        inhibit_q <= 1'b1; // R10 R21
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      ar_q <= som_pkg::AR_IDLE;
      ar_cnt_q <= '0;
      O_RESET_TRY <= 1'b0;
    end else begin
      O_RESET_TRY <= 1'b0;
      case (ar_q)
        som_pkg::AR_IDLE: begin
          ar_cnt_q <= '0;
          if (inhibit_q) begin
            ar_q <= som_pkg::AR_INHIBIT;
          end else if (ctrl_q.autoreset_en && I_STAT.error_present) begin
            ar_q <= som_pkg::AR_WAIT;
          end
        end
        som_pkg::AR_WAIT: begin
          if (inhibit_q) begin
            ar_q <= som_pkg::AR_INHIBIT; // R10
          end else if (!ctrl_q.autoreset_en || !I_STAT.error_present) begin
            ar_q <= som_pkg::AR_IDLE; // R9
          end else if (tick_q) begin
            if (ar_cnt_q == AW'(AR_TICKS - 1)) begin
              ar_cnt_q <= '0;
              O_RESET_TRY <= 1'b1; // R9
            end else begin
              ar_cnt_q <= ar_cnt_q + 1'b1;
            end
          end
        end
        som_pkg::AR_INHIBIT: ar_q <= som_pkg::AR_INHIBIT;
        default: ar_q <= som_pkg::AR_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      O_AUTORESET_INHIBIT <= 1'b0;
    end else begin
      O_AUTORESET_INHIBIT <= inhibit_q;
    end
  end

  assign stat_w = {9'h0, O_MAX_ZONE_SETS, I_STAT.error_present,
                   lock_cnt_q, inhibit_q, ovr_q, muted_q, alarm2_q, alarm1_q,
                   warn_q, pair_q};
  assign lock_w = {29'h0, lock_cnt_q};

  ////////////////////////////////////////////////////////////////////////
  // Checks
  safe_off_a: assert property ((active_viol && !keep[0]) |=> // R1
    O_PAIR1 == 2'h0) else $error("pair one stayed on in violation");
  caution_only_a: assert property ((!I_ZONE.protective_viol // R3
    && I_ZONE.zone_active && !I_STAT.fault) |=> O_PAIR1 == 2'h3)
    else $error("caution zone turned pair one off");
  warn_pol_a: assert property ((nwarn != 2'd0) |=> warn_q[0] == // R6
    ($past(ctrl_q.warn_pol[0]) ~^ $past(I_ZONE.zone_active
    & I_ZONE.caution_viol[0])))
    else $error("warning one polarity wrong");
  no_warn_a: assert property ((nwarn == 2'd0) |=> warn_q == 2'h0) // R5
    else $error("warning driven without caution zone");
  alarm1_a: assert property ((ctrl_q.alarm1_en // R7
    && I_STAT.dirty_window) |=> alarm1_q) else $error("alarm one missing");
  alarm2_a: assert property (alarm2_q |-> ($past(I_STAT.fault) // R8
    && pair_q == 3'h0)) else $error("alarm two without fault");
  third_unmuted_a: assert property ((active_viol // R11
    && npair == 2'd3) |=> !pair_q[2]) else $error("third pair muted");
  inhibit_hold_a: assert property (inhibit_q |=> (inhibit_q // R10
    && !O_RESET_TRY)) else $error("auto-reset inhibit lost");
  try_pulse_a: assert property (O_RESET_TRY |-> ($past(tick_q) // R9
    && $past(ar_q) == som_pkg::AR_WAIT) ##1 !O_RESET_TRY)
    else $error("reset attempt not a tick pulse");
  out_unsampled_a: assert property ((O_MPIN_OE // R18
    & O_MPIN_SAMPLED) == 4'h0) else $error("output pin sampled");
  display_mute_a: assert property ((|muted) |=> O_DISPLAY_MUTED) // R15
    else $error("muted state not shown");

  mute_pass_c: cover property (active_viol && muted[0] ##1 O_PAIR1 == 2'h3);
  reset_try_c: cover property (O_RESET_TRY);
  inhibit_c: cover property ($rose(inhibit_q));
  pair2_pin_c: cover property (O_MPIN_OE[0] && npair == 2'd2);

endmodule

// file: pkg/som_pkg.sv
// Shared constants, codes and carriers of the safety output manager
package som_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MPIN_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] LOCK_OFS = 8'h0c;

  // Field positions and reset values
  localparam int CTRL_W = 15;
  localparam int MFN_W = 4;
  localparam int STAT_MAXZS_POS = 16;
  localparam logic [14:0] CTRL_RST = 15'h0001;
  localparam logic [15:0] MPIN_RST = 16'h0000;

  // Timing: 1 ms tick from a 50 ns clock
  localparam int SYS_CLK_NS = 50;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = (TICK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int AUTORESET_S = 10;
  localparam int AUTORESET_MS = AUTORESET_S * 1000;
  localparam int LOCK_WIN_MIN = 15;
  localparam int LOCK_WIN_MS = LOCK_WIN_MIN * 60 * 1000;
  localparam int LOCK_MAX = 5;

  // Zone set limits, plain defaults
  localparam int ZS_MAX = 70;
  localparam int ZS_MAX_MUTED = 35;

  typedef enum logic [3:0] {
    MF_NONE = 4'h0, MF_WARN1 = 4'h1, MF_WARN2 = 4'h2, MF_LAMP1 = 4'h3,
    MF_LAMP2 = 4'h4, MF_ALARM1 = 4'h5, MF_ALARM2 = 4'h6, MF_OVR1 = 4'h7,
    MF_OVR2 = 4'h8, MF_P2A = 4'h9, MF_P2B = 4'ha, MF_P3A = 4'hb,
    MF_P3B = 4'hc
  } som_mfunc_t;

  typedef enum logic [2:0] {
    AR_IDLE = 3'h1, AR_WAIT = 3'h2, AR_INHIBIT = 3'h4
  } som_ar_t;

  typedef struct packed {
    logic zone_active;
    logic protective_viol;
    logic [1:0] caution_viol;
  } som_zone_t;

  typedef struct packed {
    logic fault;
    logic dirty_window;
    logic lockout_evt;
    logic error_present;
  } som_stat_t;

  typedef struct packed {
    logic [1:0] ovr_en;
    logic [1:0] lamp_en;
    logic [1:0] mute_en;
    logic autoreset_en;
    logic alarm2_en;
    logic alarm1_en;
    logic [1:0] warn_pol;
    logic [1:0] warn_cnt;
    logic [1:0] pair_cnt;
  } som_ctrl_t;

endpackage

// file: testbench/som_mach_model.sv
// Machine-side model: mute sensors and stop detection
`timescale 1ns/10ps
module som_mach_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_mute_req,
  input wire logic [1:0] i_pair,
  output logic [1:0] o_mute_sensor,
  output logic o_stopped
);
  // Sensors fire one after the other, as a passing load would
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mute_sensor <= 2'h0;
    end else begin
      o_mute_sensor[0] <= i_mute_req;
      o_mute_sensor[1] <= o_mute_sensor[0] & i_mute_req;
    end
  end
  // Stop when either half goes off
  assign o_stopped = ~&i_pair;
endmodule

// file: testbench/safety_output_manager_bench.sv
// Self-checking bench of the safety output manager
`timescale 1ns/10ps
module safety_output_manager_bench;
  logic clk, rst, cyc, stb, we, ack, ovr, mute_req, stopped, rtry, inh, dm;
  logic [7:0] adr;
  logic [3:0] sel, min, mo, moe, msmp;
  logic [31:0] wd, rd, r;
  logic [1:0] p1, ms;
  logic [6:0] mzs;
  som_pkg::som_zone_t zone;
  som_pkg::som_stat_t stat;
  int n_fail, checks, k, on, occ, pol, alm;
  ////////////////////////////////////////////////////////////////
  som_top #(.TICK_CYC(4), .AR_TICKS(3), .WIN_TICKS(20)) dut_u (
    .I_SYS_CLK(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wd),
    .O_WB_DAT(rd), .O_WB_ACK(ack), .I_ZONE(zone), .I_STAT(stat),
    .I_MUTE_SENSOR(ms), .I_OVERRIDE(ovr), .I_MPIN_IN(min),
    .O_PAIR1(p1), .O_MPIN_OUT(mo), .O_MPIN_OE(moe),
    .O_MPIN_SAMPLED(msmp), .O_DISPLAY_MUTED(dm), .O_RESET_TRY(rtry),
    .O_AUTORESET_INHIBIT(inh), .O_MAX_ZONE_SETS(mzs));
  som_mach_model mach_u (.i_clk(clk), .i_rst(rst), .i_mute_req(mute_req),
    .i_pair(p1),
    .o_mute_sensor(ms), .o_stopped(stopped));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= 4'hf;
    // Only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wd = 32'h0;
    sel = 4'h0; zone = '0; stat = '0; ovr = 1'b0; mute_req = 1'b0;
    min = 4'h0; n_fail = 0; checks = 0;
    settle(8);
    rst <= 1'b0;
    void'($urandom(9532));
    check(mzs, 32'h46);
    wb(0, som_pkg::CTRL_OFS, 0); check(r, 32'h1);
    wb(0, som_pkg::MPIN_OFS, 0); check(r, 32'h0);
    wb(0, 8'h10, 0); check(r, 32'h0);
    // Random zones against inline expectations, two pairs with pair 2 on pins 0/1
    for (k = 0; k < 16; k++) begin
      pol = $urandom % 2;
      alm = k % 2;
      wb(1, som_pkg::CTRL_OFS, 32'hc6 | (pol << 4));
      wb(1, som_pkg::MPIN_OFS, alm ? 32'h61a9 : 32'h51a9);
      @(posedge clk);
      zone <= som_pkg::som_zone_t'(4'($urandom));
      stat <= som_pkg::som_stat_t'(4'($urandom) & 4'hc);
      min <= 4'($urandom);
      settle(5);
      on = zone.zone_active && !zone.protective_viol && !stat.fault;
      occ = zone.zone_active && zone.caution_viol[0];
      check(p1, {1'(on), 1'(on)});
      check(mo[1:0], {1'(on), 1'(on)});
      check(mo[2], pol ? occ : !occ);
      check(mo[3], alm ? stat.fault : stat.dirty_window);
      check(moe, 4'hf);
      check(msmp, 4'h0);
    end
    zone <= '{1'b1, 1'b0, 2'b11};
    stat <= '0;
    wb(1, som_pkg::CTRL_OFS, 32'h1);
    settle(5);
    check(p1, 2'h3);
    check(mo[2], 1'b0);
    check(moe[1:0], 2'h0);
    check(msmp, {1'b0, min[2:0]});
    wb(0, som_pkg::STAT_OFS, 0);
    check(r, 32'h00460001);
    // Muting pairs 1 and 2, pair 3 on pins 0/1, lamp on pin 2
    wb(1, som_pkg::CTRL_OFS, 32'h1e03);
    wb(1, som_pkg::MPIN_OFS, 32'h3cb);
    zone <= '{1'b1, 1'b1, 2'b00};
    mute_req <= 1'b1;
    settle(8);
    check(p1, 2'h3);
    check(stopped, 1'b0);
    check(mo[1:0], 2'h0);
    check(mo[2], 1'b1);
    check(dm, 1'b1);
    check(mzs, 32'h23);
    mute_req <= 1'b0;
    settle(8);
    check(p1, 2'h0);
    check(dm, 1'b0);
    // Override forces pair 1 on only with muting enabled
    wb(1, som_pkg::CTRL_OFS, 32'h2201);
    wb(1, som_pkg::MPIN_OFS, 32'h7);
    ovr <= 1'b1;
    settle(8);
    check(p1, 2'h3);
    check(mo[0], 1'b1);
    wb(1, som_pkg::CTRL_OFS, 32'h2001);
    settle(5);
    check(p1, 2'h0);
    check(mo[0], 1'b0);
    ovr <= 1'b0;
    // Auto-reset pulses every 3 ticks of 4 cycles
    wb(1, som_pkg::CTRL_OFS, 32'h101);
    stat.error_present <= 1'b1;
    on = 0;
    repeat (120) begin
      @(posedge clk);
      on += (rtry === 1'b1);
    end
    check(on >= 9 && on <= 11, 1'b1);
    stat.error_present <= 1'b0;
    settle(3);
    on = 0;
    repeat (40) begin
      @(posedge clk);
      on += (rtry === 1'b1);
    end
    check(on, 0);
    // Six lockouts inside the window inhibit auto-reset
    for (k = 0; k < 6; k++) begin
      check(inh, 1'b0);
      stat.lockout_evt <= 1'b1;
      @(posedge clk);
      stat.lockout_evt <= 1'b0;
      @(posedge clk);
    end
    settle(2);
    check(inh, 1'b1);
    wb(1, som_pkg::LOCK_OFS, 32'h0);
    wb(0, som_pkg::LOCK_OFS, 0); check(r[2:0], 3'h6);
    stat.error_present <= 1'b1;
    on = 0;
    repeat (60) begin
      @(posedge clk);
      on += (rtry === 1'b1);
    end
    check(on, 0);
    settle(200);
    check(inh, 1'b1);
    rst <= 1'b1;
    settle(2);
    rst <= 1'b0;
    settle(2);
    check(inh, 1'b0);
    report_and_stop();
  end
endmodule
